/* File: design/uvc_pkg.sv */
// Purpose: Shared constants for the vendor command register access block
// Assumes: 40 MHz system clock
// Notes:   Addresses are 8-bit; internal space below the external base
package uvc_pkg;
	// ==========================================================
	// Request encodings
	localparam int          DIR_BIT      = 7;
	localparam int          FIXED_BIT    = 0;
	localparam int          WIDTH_LSB    = 1;
	localparam int          CHECK_BIT    = 3;
	// ==========================================================
	// Address map seen by vendor commands
	localparam logic [7:0]  EXT_BASE     = 8'hC0;
	localparam logic [7:0]  IR_OPS_LO    = 8'h05;
	localparam logic [7:0]  IR_OPS_HI    = 8'h06;
	localparam logic [7:0]  IR_AUX_LVL   = 8'h12;
	localparam logic [7:0]  IR_POLL_LOC  = 8'h18;
	localparam int          POLL_EN_HI   = 7;
	localparam int          POLL_EN_LO   = 6;
	// ==========================================================
	// APB register map
	localparam logic [7:0]  APB_CTRL     = 8'h00;
	localparam logic [7:0]  APB_STATUS   = 8'h04;
	localparam logic [7:0]  APB_POLL     = 8'h08;
	localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0000;
	localparam logic [7:0]  POLL_RST_VAL = 8'h00;
	// ==========================================================
	// Strobe timing: widths are in 24 MHz cycles, rounded up to 40 MHz
	localparam int          SYS_CYC_NS   = 42;
	localparam int          CLK_NS       = 25;
	localparam int          W0_SYS       = 2;
	localparam int          W1_SYS       = 3;
	localparam int          W2_SYS       = 8;
	localparam int          W3_SYS       = 16;
	localparam logic [4:0]  W0_CYC = 5'((W0_SYS * SYS_CYC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0]  W1_CYC = 5'((W1_SYS * SYS_CYC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0]  W2_CYC = 5'((W2_SYS * SYS_CYC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0]  W3_CYC = 5'((W3_SYS * SYS_CYC_NS + CLK_NS - 1) / CLK_NS);
	// ==========================================================
	typedef enum logic [5:0] {
		S_IDLE = 6'b00_0001,
		S_GET  = 6'b00_0010,
		S_ACC  = 6'b00_0100,
		S_WAIT = 6'b00_1000,
		S_PUT  = 6'b01_0000,
		S_HOLD = 6'b10_0000
	} uvc_state_t;
	typedef enum logic [1:0] {
		P_CHK  = 2'b00,
		P_XFER = 2'b01,
		P_POLL = 2'b10
	} uvc_purp_t;
endpackage

/* File: design/uvc_acc_if.sv */
// Purpose: Request and answer between command core and bus engine
// Assumes: One request in flight at a time
// Notes:   req is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface uvc_acc_if;
	logic       req;
	logic       we;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [1:0] width;
	logic       done;
	logic [7:0] rdata;
	modport core (output req, we, addr, wdata, width, input done, rdata);
	modport eng  (input req, we, addr, wdata, width, output done, rdata);
endinterface
`default_nettype wire

/* File: design/uvc_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are quasi-static relative to sampling
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module uvc_sync #(
	parameter int W = 8
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_d,
	output var  logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_reg <= '0;
			o_q      <= '0;
		end else begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* File: design/uvc_pib_eng.sv */
// Purpose: One peripheral bus access with programmable strobe width
// Assumes: Read data arrives already synchronised
// Notes:   Address and data are held for the whole strobe
`timescale 1ns/10ps
`default_nettype none
module uvc_pib_eng (
	input  wire logic       i_clock,
	input  wire logic       i_rst_b,
	uvc_acc_if.eng          acc,
	input  wire logic [7:0] i_data_sync,
	output var  logic [5:0] o_addr,
	output var  logic [7:0] o_wdata,
	output var  logic       o_oe_b,
	output var  logic       o_rd_n,
	output var  logic       o_wr_n
);
	logic [4:0] cnt_reg, cnt_next;
	logic       busy_reg, busy_next;
	logic       we_reg, we_next;
	logic [5:0] addr_next;
	logic [7:0] wdata_next, rdata_next;
	logic       done_next;
	logic [4:0] width_cyc;

	always_comb begin
		unique case (acc.width)
			2'd0: width_cyc = uvc_pkg::W0_CYC;
			2'd1: width_cyc = uvc_pkg::W1_CYC;
			2'd2: width_cyc = uvc_pkg::W2_CYC;
			2'd3: width_cyc = uvc_pkg::W3_CYC;
		endcase
	end

	always_comb begin
		cnt_next   = cnt_reg;
		busy_next  = busy_reg;
		we_next    = we_reg;
		addr_next  = o_addr;
		wdata_next = o_wdata;
		rdata_next = acc.rdata;
		done_next  = 1'b0;
		if (!busy_reg && acc.req) begin
			busy_next  = 1'b1;
			cnt_next   = width_cyc;
			we_next    = acc.we;
			addr_next  = acc.addr;
			wdata_next = acc.wdata;
		end else if (busy_reg) begin
			cnt_next = cnt_reg - 5'd1;
			if (cnt_reg == 5'd1) begin
				busy_next = 1'b0;
				done_next = 1'b1;
				if (!we_reg) begin
					rdata_next = i_data_sync;
				end
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_reg   <= '0;
			busy_reg  <= 1'b0;
			we_reg    <= 1'b0;
			o_addr    <= '0;
			o_wdata   <= '0;
			acc.rdata <= '0;
			acc.done  <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			busy_reg  <= busy_next;
			we_reg    <= we_next;
			o_addr    <= addr_next;
			o_wdata   <= wdata_next;
			acc.rdata <= rdata_next;
			acc.done  <= done_next;
		end
	end

	// Strobes and drive only while busy; address is never changed mid-strobe
	assign o_rd_n = !(busy_reg && !we_reg);
	assign o_wr_n = !(busy_reg && we_reg);
	assign o_oe_b = !(busy_reg && we_reg);

	// ==========================================================
	// Checks
	logic [4:0] low_cnt_reg;
	logic [4:0] exp_reg;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_cnt_reg <= '0;
			exp_reg     <= '0;
		end else begin
			low_cnt_reg <= busy_reg ? low_cnt_reg + 5'd1 : 5'd0;
			if (!busy_reg && acc.req) begin
				exp_reg <= width_cyc;
			end
		end
	end
	property p_strobe_len;
		@(posedge i_clock) disable iff (!i_rst_b)
		acc.done |-> low_cnt_reg == exp_reg;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("Strobe width wrong");
	property p_addr_hold;
		@(posedge i_clock) disable iff (!i_rst_b)
		(busy_reg && $past(busy_reg)) |-> $stable(o_addr) && $stable(o_wdata);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("Address moved in strobe");
endmodule
`default_nettype wire

/* File: design/uvc_cmd_core.sv */
// Purpose: Vendor command interpreter for register and peripheral access
// Assumes: USB engine delivers setup fields, data-stage bytes and SOF pulses
// Notes:   Status poll runs only between commands
// Contract
// - Request-type bit 7 selects read or write
// - Request bit 0 holds address fixed
// - Request bits 2:1 pick strobe width
// - Strobe widths counted in 42 ns cycles
// - Request bit 3 enables check mode
// - Value low is status address, high mask
// - Zero masked status halts the command
// - Completed operations readable at 0x05/0x06; here the count is 8-bit at 0x05 and 0x06 reads 0
// - Index low byte is start address
// - Below 0xC0 internal, no strobes
// - 0xC0 and up strobe peripheral bus
// - Length low byte is transfer count
// - Two interrupt bytes every frame
// - Aux levels then polled peripheral status
// - Poll only when location bits 7:6 set
// - Poll per SOF, never during commands
// - Many transfers per command, own timing
// - Six address, eight data, strobes, reset
// - Aux levels readable at 0x12
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module uvc_cmd_core (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output var  logic [31:0] o_prdata,
	output var  logic        o_pready,
	output var  logic        o_pslverr,
	input  wire logic        i_setup_valid,
	output var  logic        o_setup_ready,
	input  wire logic [7:0]  i_req_type,
	input  wire logic [7:0]  i_request,
	input  wire logic [15:0] i_value,
	input  wire logic [15:0] i_index,
	input  wire logic [15:0] i_length,
	input  wire logic        i_out_valid,
	input  wire logic [7:0]  i_out_data,
	output var  logic        o_out_ready,
	output var  logic        o_in_valid,
	output var  logic [7:0]  o_in_data,
	input  wire logic        i_in_ready,
	input  wire logic        i_sof,
	output var  logic        o_int_valid,
	output var  logic [7:0]  o_int_aux,
	output var  logic [7:0]  o_int_stat,
	input  wire logic [6:0]  i_aux_pins,
	output var  logic [5:0]  o_periph_addr_lines,
	output var  logic [7:0]  o_periph_data_lines,
	output var  logic        o_periph_data_lines_oe_b,
	input  wire logic [7:0]  i_periph_data_lines,
	output var  logic        o_periph_rd_n,
	output var  logic        o_periph_wr_n,
	output var  logic        o_periph_reset_out_n
);
	// ==========================================================
	// Pin synchronisers
	logic [14:0] sync_q;
	logic [6:0]  aux_lvl;
	logic [7:0]  pdata_sync;
	uvc_sync #(.W(15)) u_sync (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.i_d     ({i_aux_pins, i_periph_data_lines}),
		.o_q     (sync_q)
	);
	assign aux_lvl    = sync_q[14:8];
	assign pdata_sync = sync_q[7:0];

	// ==========================================================
	// Peripheral bus engine
	uvc_acc_if acc ();
	uvc_pib_eng u_eng (
		.i_clock     (i_clock),
		.i_rst_b     (i_rst_b),
		.acc         (acc.eng),
		.i_data_sync (pdata_sync),
		.o_addr      (o_periph_addr_lines),
		.o_wdata     (o_periph_data_lines),
		.o_oe_b      (o_periph_data_lines_oe_b),
		.o_rd_n      (o_periph_rd_n),
		.o_wr_n      (o_periph_wr_n)
	);

	// ==========================================================
	// Command state
	uvc_pkg::uvc_state_t state_reg, state_next;
	uvc_pkg::uvc_purp_t  purp_reg, purp_next;
	logic       rd_reg, rd_next;
	logic       fixed_reg, fixed_next;
	logic       chk_reg, chk_next;
	logic [1:0] width_reg, width_next;
	logic [7:0] stat_addr_reg, stat_addr_next;
	logic [7:0] mask_reg, mask_next;
	logic [7:0] addr_reg, addr_next;
	logic [7:0] left_reg, left_next;
	logic [7:0] ops_reg, ops_next;
	logic [7:0] acc_addr_reg, acc_addr_next;
	logic [7:0] data_reg, data_next;
	logic       halted_reg, halted_next;
	logic       poll_pend_reg, poll_pend_next;
	logic [7:0] poll_loc_reg, poll_loc_next;
	logic       int_valid_next;
	logic [7:0] int_stat_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic       have_res, after_xfer, step, xfer_go, ext, poll_en;
	logic [7:0] res;
	logic       apb_wr;

	assign ext     = acc_addr_reg >= uvc_pkg::EXT_BASE;
	assign poll_en = poll_loc_reg[uvc_pkg::POLL_EN_HI] && poll_loc_reg[uvc_pkg::POLL_EN_LO];
	assign apb_wr  = i_psel && i_penable && i_pwrite;

	function automatic logic [7:0] int_rd(input logic [7:0] a, input logic [7:0] ops,
		input logic [6:0] aux, input logic [7:0] loc);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			uvc_pkg::IR_OPS_LO:   v = ops;
			uvc_pkg::IR_AUX_LVL:  v = {1'b0, aux};
			uvc_pkg::IR_POLL_LOC: v = loc;
			default:              v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb begin
		state_next     = state_reg;
		purp_next      = purp_reg;
		rd_next        = rd_reg;
		fixed_next     = fixed_reg;
		chk_next       = chk_reg;
		width_next     = width_reg;
		stat_addr_next = stat_addr_reg;
		mask_next      = mask_reg;
		addr_next      = addr_reg;
		left_next      = left_reg;
		ops_next       = ops_reg;
		acc_addr_next  = acc_addr_reg;
		data_next      = data_reg;
		halted_next    = halted_reg;
		poll_pend_next = poll_pend_reg;
		poll_loc_next  = poll_loc_reg;
		ctrl_next      = ctrl_reg;
		int_valid_next = 1'b0;
		int_stat_next  = o_int_stat;
		have_res       = 1'b0;
		after_xfer     = 1'b0;
		step           = 1'b0;
		xfer_go        = 1'b0;
		res            = 8'h00;
		acc.req        = 1'b0;
		unique case (state_reg)
			uvc_pkg::S_IDLE: begin
				if (poll_pend_reg) begin
					poll_pend_next = 1'b0;
					if (poll_en) begin
						purp_next     = uvc_pkg::P_POLL;
						acc_addr_next = {2'b11, poll_loc_reg[5:0]};
						state_next    = uvc_pkg::S_ACC;
					end else begin
						int_valid_next = 1'b1;
					end
				end else if (i_setup_valid) begin
					rd_next        = i_req_type[uvc_pkg::DIR_BIT];
					fixed_next     = i_request[uvc_pkg::FIXED_BIT];
					width_next     = i_request[uvc_pkg::WIDTH_LSB +: 2];
					chk_next       = i_request[uvc_pkg::CHECK_BIT];
					stat_addr_next = i_value[7:0];
					mask_next      = i_value[15:8];
					addr_next      = i_index[7:0];
					left_next      = i_length[7:0];
					// Only a checking command restarts the count, so a later read keeps it
					if (i_request[uvc_pkg::CHECK_BIT]) begin
						ops_next    = 8'h00;
						halted_next = 1'b0;
					end
					step           = i_length[7:0] != 8'h00;
				end
			end
			uvc_pkg::S_GET: begin
				if (i_out_valid) begin
					data_next  = i_out_data;
					state_next = uvc_pkg::S_ACC;
				end
			end
			uvc_pkg::S_ACC: begin
				if (ext) begin
					acc.req    = 1'b1;
					state_next = uvc_pkg::S_WAIT;
				end else begin
					res      = int_rd(acc_addr_reg, ops_reg, aux_lvl, poll_loc_reg);
					have_res = 1'b1;
					if (purp_reg == uvc_pkg::P_XFER && !rd_reg
						&& acc_addr_reg == uvc_pkg::IR_POLL_LOC) begin
						poll_loc_next = data_reg;
					end
				end
			end
			uvc_pkg::S_WAIT: begin
				if (acc.done) begin
					res      = acc.rdata;
					have_res = 1'b1;
				end
			end
			uvc_pkg::S_PUT: begin
				if (i_in_ready) begin
					after_xfer = 1'b1;
				end
			end
			uvc_pkg::S_HOLD: begin
				state_next = uvc_pkg::S_IDLE;
			end
		endcase
		if (have_res) begin
			unique case (purp_reg)
				uvc_pkg::P_CHK: begin
					if ((res & mask_reg) != 8'h00) begin
						xfer_go = 1'b1;
					end else begin
						halted_next = 1'b1;
						state_next  = uvc_pkg::S_IDLE;
					end
				end
				uvc_pkg::P_XFER: begin
					if (rd_reg) begin
						data_next  = res;
						state_next = uvc_pkg::S_PUT;
					end else begin
						after_xfer = 1'b1;
					end
				end
				default: begin
					int_stat_next  = res;
					int_valid_next = 1'b1;
					state_next     = uvc_pkg::S_IDLE;
				end
			endcase
		end
		if (after_xfer) begin
			ops_next  = chk_reg ? ops_reg + 8'd1 : ops_reg;
			addr_next = fixed_reg ? addr_reg : addr_reg + 8'd1;
			left_next = left_reg - 8'd1;
			if (left_reg == 8'd1) begin
				state_next = uvc_pkg::S_HOLD;
			end else begin
				step = 1'b1;
			end
		end
		if (step) begin
			if (chk_next) begin
				purp_next     = uvc_pkg::P_CHK;
				acc_addr_next = stat_addr_next;
				state_next    = uvc_pkg::S_ACC;
			end else begin
				xfer_go = 1'b1;
			end
		end
		if (xfer_go) begin
			purp_next     = uvc_pkg::P_XFER;
			acc_addr_next = addr_next;
			state_next    = rd_next ? uvc_pkg::S_ACC : uvc_pkg::S_GET;
		end
		// SOF arriving while the pending flag clears still counts
		if (i_sof) begin
			poll_pend_next = 1'b1;
		end
		if (apb_wr && i_paddr == uvc_pkg::APB_CTRL) begin
			ctrl_next = i_pwdata;
		end
		if (apb_wr && i_paddr == uvc_pkg::APB_POLL) begin
			poll_loc_next = i_pwdata[7:0];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg     <= uvc_pkg::S_IDLE;
			purp_reg      <= uvc_pkg::P_CHK;
			rd_reg        <= 1'b0;
			fixed_reg     <= 1'b0;
			chk_reg       <= 1'b0;
			width_reg     <= 2'd0;
			stat_addr_reg <= '0;
			mask_reg      <= '0;
			addr_reg      <= '0;
			left_reg      <= '0;
			ops_reg       <= '0;
			acc_addr_reg  <= '0;
			data_reg      <= '0;
			halted_reg    <= 1'b0;
			poll_pend_reg <= 1'b0;
			poll_loc_reg  <= uvc_pkg::POLL_RST_VAL;
			ctrl_reg      <= uvc_pkg::CTRL_RST_VAL;
			o_int_valid   <= 1'b0;
			o_int_stat    <= '0;
			o_int_aux     <= '0;
		end else begin
			state_reg     <= state_next;
			purp_reg      <= purp_next;
			rd_reg        <= rd_next;
			fixed_reg     <= fixed_next;
			chk_reg       <= chk_next;
			width_reg     <= width_next;
			stat_addr_reg <= stat_addr_next;
			mask_reg      <= mask_next;
			addr_reg      <= addr_next;
			left_reg      <= left_next;
			ops_reg       <= ops_next;
			acc_addr_reg  <= acc_addr_next;
			data_reg      <= data_next;
			halted_reg    <= halted_next;
			poll_pend_reg <= poll_pend_next;
			poll_loc_reg  <= poll_loc_next;
			ctrl_reg      <= ctrl_next;
			o_int_valid   <= int_valid_next;
			o_int_stat    <= int_stat_next;
			o_int_aux     <= {1'b0, aux_lvl};
		end
	end

	// ==========================================================
	// Engine request fields and user handshakes
	assign acc.we   = !rd_reg && purp_reg == uvc_pkg::P_XFER;
	assign acc.addr = acc_addr_reg[5:0];
	assign acc.wdata = data_reg;
	assign acc.width = width_reg;
	// Setup is refused while a poll waits, so the poll cannot be starved
	assign o_setup_ready = state_reg == uvc_pkg::S_IDLE && !poll_pend_reg;
	assign o_out_ready   = state_reg == uvc_pkg::S_GET;
	assign o_in_valid    = state_reg == uvc_pkg::S_PUT;
	assign o_in_data     = data_reg;
	assign o_periph_reset_out_n = !ctrl_reg[0];

	// ==========================================================
	// APB slave, zero wait states
	always_comb begin
		o_prdata  = 32'h0000_0000;
		o_pslverr = 1'b0;
		unique case (i_paddr)
			uvc_pkg::APB_CTRL:   o_prdata = ctrl_reg;
			uvc_pkg::APB_STATUS: o_prdata = {16'h0000, ops_reg, 6'd0, halted_reg,
				state_reg != uvc_pkg::S_IDLE};
			uvc_pkg::APB_POLL:   o_prdata = {24'h00_0000, poll_loc_reg};
			default:             o_pslverr = i_psel && i_penable;
		endcase
	end
	assign o_pready = 1'b1;

	// ==========================================================
	// Checks
	property p_no_int_strobe;
		@(posedge i_clock) disable iff (!i_rst_b)
		(state_reg == uvc_pkg::S_ACC && !ext) |=> o_periph_rd_n && o_periph_wr_n;
	endproperty
	a_no_int_strobe: assert property (p_no_int_strobe) else $error("Strobe on internal");
	property p_fixed_addr;
		@(posedge i_clock) disable iff (!i_rst_b)
		(after_xfer && fixed_reg) |=> addr_reg == $past(addr_reg);
	endproperty
	a_fixed_addr: assert property (p_fixed_addr) else $error("Fixed address moved");
	property p_incr_addr;
		@(posedge i_clock) disable iff (!i_rst_b)
		(after_xfer && !fixed_reg) |=> addr_reg == $past(addr_reg) + 8'd1;
	endproperty
	a_incr_addr: assert property (p_incr_addr) else $error("Address not incremented");
	property p_halt;
		@(posedge i_clock) disable iff (!i_rst_b)
		(have_res && purp_reg == uvc_pkg::P_CHK && (res & mask_reg) == 8'h00)
			|=> halted_reg && state_reg == uvc_pkg::S_IDLE;
	endproperty
	a_halt: assert property (p_halt) else $error("Check failure did not halt");
	property p_rd_dir;
		@(posedge i_clock) disable iff (!i_rst_b)
		o_in_valid |-> rd_reg && purp_reg == uvc_pkg::P_XFER;
	endproperty
	a_rd_dir: assert property (p_rd_dir) else $error("Read data on write command");
	property p_poll_en;
		@(posedge i_clock) disable iff (!i_rst_b)
		(acc.req && purp_reg == uvc_pkg::P_POLL) |-> poll_en;
	endproperty
	a_poll_en: assert property (p_poll_en) else $error("Poll while disabled");
	property p_sof_int;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_sof && state_reg == uvc_pkg::S_IDLE && !poll_pend_reg && !i_setup_valid)
			|-> ##[1:40] o_int_valid;
	endproperty
	a_sof_int: assert property (p_sof_int) else $error("No interrupt report");
	property p_no_setup_busy;
		@(posedge i_clock) disable iff (!i_rst_b)
		(state_reg == uvc_pkg::S_ACC && purp_reg == uvc_pkg::P_POLL)
			|-> $past(state_reg) == uvc_pkg::S_IDLE;
	endproperty
	a_no_setup_busy: assert property (p_no_setup_busy) else $error("Poll started mid-command");
	c_read:  cover property (@(posedge i_clock) o_in_valid && i_in_ready);
	c_halt:  cover property (@(posedge i_clock) $rose(halted_reg));
	c_poll:  cover property (@(posedge i_clock) o_int_valid && poll_en);
endmodule
`default_nettype wire

/* File: test/uvc_periph_model.sv */
// Purpose: Peripheral chip on the parallel bus
// Assumes: Active-low strobes, no pull resistors on the data lines
// Notes:   Memory is reachable from the bench by hierarchy
`timescale 1ns/10ps
`default_nettype none
module uvc_periph_model (
	input  wire logic       i_clock,
	input  wire logic [5:0] i_addr,
	input  wire logic [7:0] i_bus,
	input  wire logic       i_rd_n,
	input  wire logic       i_wr_n,
	output var  logic [7:0] o_drive
);
	logic [7:0] mem [64];
	logic [7:0] last_q = 8'h00;
	// ====
	// Released bus shows the inverse of the last value, so stale data is caught
	always_comb begin
		o_drive = i_rd_n ? ~last_q : mem[i_addr];
	end
	always @(posedge i_clock) begin
		if (!i_rd_n) begin
			last_q <= mem[i_addr];
		end
		if (!i_wr_n) begin
			mem[i_addr] <= i_bus;
		end
	end
endmodule
`default_nettype wire

/* File: test/test_usb_vendor_cmd_register_access.sv */
// Purpose: Self-checking bench for the vendor command block
// Assumes: Strobe widths follow the 42 ns unit on a 25 ns clock
// Notes:   Every wait is bounded by lim
`timescale 1ns/10ps
`default_nettype none
module test_usb_vendor_cmd_register_access;
	localparam int lim = 3000;
	logic i_clock, i_rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, rtype, rq, od, idat, intaux, intstat, pd, mdrv, bus, b;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] val, idx, len;
	logic sv, srdy, ov, ordy, iv, irdy, sof, intv, oe_b, rd_n, wr_n, rst_o_n, e;
	logic [6:0] aux;
	logic [5:0] pa;
	int bad_count = 0, checks = 0, run = 0, lastw = 0, nstb = 0, n0;
	int tbl [4] = '{2, 3, 8, 16};
	assign bus = !oe_b ? pd : mdrv;
	uvc_cmd_core u_uvc_cmd_core (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_setup_valid(sv),
		.o_setup_ready(srdy), .i_req_type(rtype), .i_request(rq), .i_value(val),
		.i_index(idx), .i_length(len), .i_out_valid(ov), .i_out_data(od),
		.o_out_ready(ordy), .o_in_valid(iv), .o_in_data(idat), .i_in_ready(irdy),
		.i_sof(sof), .o_int_valid(intv), .o_int_aux(intaux), .o_int_stat(intstat),
		.i_aux_pins(aux), .o_periph_addr_lines(pa), .o_periph_data_lines(pd),
		.o_periph_data_lines_oe_b(oe_b), .i_periph_data_lines(bus),
		.o_periph_rd_n(rd_n), .o_periph_wr_n(wr_n), .o_periph_reset_out_n(rst_o_n));
	uvc_periph_model u_uvc_periph_model (.i_clock(i_clock), .i_addr(pa), .i_bus(bus),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .o_drive(mdrv));
	// ====
	// Strobe monitor: length of the last strobe and count of strobes
	always @(posedge i_clock) begin
		if (rd_n === 1'b0 || wr_n === 1'b0) begin
			run <= run + 1;
		end else if (run != 0) begin
			lastw <= run;
			nstb <= nstb + 1;
			run <= 0;
		end
	end
	task automatic stop_test;
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= lim) begin
			bad_count++;
			$display("Error %0t: wait ran out", $time);
			stop_test();
		end
	endtask
	// ====
	// Bus and host tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		for (n = 0; n < lim; n++) begin
			@(posedge i_clock);
			if (pready === 1'b1) break;
		end
		tmo(n);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge i_clock);
	endtask
	task automatic vc(input logic [7:0] t, q, input logic [15:0] v, x, l);
		int n;
		@(posedge i_clock);
		sv <= 1'b1;
		rtype <= t;
		rq <= q;
		val <= v;
		idx <= x;
		len <= l;
		for (n = 0; n < lim; n++) begin
			@(posedge i_clock);
			if (srdy === 1'b1) break;
		end
		tmo(n);
		sv <= 1'b0;
	endtask
	task automatic getb;
		int n;
		@(posedge i_clock);
		irdy <= 1'b1;
		for (n = 0; n < lim; n++) begin
			@(posedge i_clock);
			if (iv === 1'b1) break;
		end
		tmo(n);
		b = idat;
		irdy <= 1'b0;
	endtask
	task automatic putb(input logic [7:0] d);
		int n;
		@(posedge i_clock);
		ov <= 1'b1;
		od <= d;
		for (n = 0; n < lim; n++) begin
			@(posedge i_clock);
			if (ordy === 1'b1) break;
		end
		tmo(n);
		ov <= 1'b0;
	endtask
	task automatic idle;
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge i_clock);
			if (srdy === 1'b1 && intv !== 1'b1) break;
		end
		tmo(n);
		@(negedge i_clock);
	endtask
	task automatic frame;
		int n;
		@(posedge i_clock);
		sof <= 1'b1;
		@(posedge i_clock);
		sof <= 1'b0;
		for (n = 0; n < lim; n++) begin
			@(posedge i_clock);
			if (intv === 1'b1) break;
		end
		tmo(n);
		@(negedge i_clock);
	endtask
	// ====
	// Scenarios
	task automatic t_apb;
		apb(1'b0, uvc_pkg::APB_CTRL, 32'h0000_0000);
		chk(r, uvc_pkg::CTRL_RST_VAL);
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		apb(1'b1, uvc_pkg::APB_CTRL, 32'h0000_0001);
		chk({31'h0, rst_o_n}, 32'h0000_0000);
		apb(1'b1, uvc_pkg::APB_CTRL, 32'h0000_0000);
		chk({31'h0, rst_o_n}, 32'h0000_0001);
	endtask
	task automatic t_ext;
		n0 = nstb;
		vc(8'hC0 & 8'h40, 8'h00, 16'h0000, 16'hFFC4, 16'hAB02);
		putb(8'hA5);
		putb(8'h5A);
		idle();
		chk(u_uvc_periph_model.mem[4], 8'hA5);
		chk(u_uvc_periph_model.mem[5], 8'h5A);
		chk(nstb - n0, 2);
		vc(8'hC0, 8'h00, 16'h0000, 16'h00C4, 16'h0002);
		getb();
		chk(b, 8'hA5);
		getb();
		chk(b, 8'h5A);
	endtask
	task automatic t_width;
		for (int w = 0; w < 4; w++) begin
			vc(8'hC0, {5'h00, 2'(w), 1'b1}, 16'h0000, 16'h00C4, 16'h0002);
			getb();
			chk(b, 8'hA5);
			getb();
			chk(b, 8'hA5);
			idle();
			chk(lastw, (tbl[w] * 42 + 24) / 25);
		end
	endtask
	task automatic t_int;
		n0 = nstb;
		vc(8'h40, 8'h00, 16'h0000, 16'h0018, 16'h0001);
		putb(8'hC7);
		idle();
		vc(8'hC0, 8'h00, 16'h0000, 16'h0012, 16'h0001);
		getb();
		chk(b, {1'b0, aux});
		idle();
		chk(nstb, n0);
		frame();
		chk(intstat, 8'h3C);
		chk(intaux, {1'b0, aux});
		chk(nstb, n0 + 1);
		u_uvc_periph_model.mem[7] = 8'h11;
		vc(8'h40, 8'h00, 16'h0000, 16'h0018, 16'h0001);
		putb(8'h07);
		idle();
		frame();
		chk(intstat, 8'h3C);
		chk(nstb, n0 + 1);
	endtask
	task automatic t_check;
		n0 = nstb;
		vc(8'h40, 8'h09, 16'hFFC5, 16'h00C5, 16'h0003);
		putb(8'h00);
		idle();
		chk(u_uvc_periph_model.mem[5], 8'h00);
		chk(nstb - n0, 3);
		vc(8'hC0, 8'h00, 16'h0000, 16'h0005, 16'h0001);
		getb();
		chk(b, 8'h01);
		apb(1'b0, uvc_pkg::APB_STATUS, 32'h0000_0000);
		chk(r[15:8], 8'h01);
		chk(r[1], 1'b1);
	endtask
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	initial begin
		{psel, penable, pwrite, sv, ov, irdy, sof} = 7'h00;
		{paddr, rtype, rq, od} = 32'h0000_0000;
		{pwdata, val, idx, len} = 80'h0;
		aux = 7'h2D;
		i_rst_b = 1'b0;
		u_uvc_periph_model.mem[7] = 8'h3C;
		repeat (20) @(posedge i_clock);
		i_rst_b <= 1'b1;
		t_apb();
		t_ext();
		t_width();
		t_int();
		t_check();
		stop_test();
	end
endmodule
`default_nettype wire
